// *** hdl/tio_pkg.sv ***
// package: constants and helpers for the timed i/o port block
`default_nettype none
package tio_pkg;
  localparam int NPORT     = 5;
  localparam int NCLK      = 6;
  localparam int NPIN      = 32;
  localparam int LINK_PINS = 4;
  localparam int CLK_HZ    = 40_000_000;
  localparam int REF_HZ    = 100_000_000;
  // reference outruns clk_in: block 0 then ticks once per cycle
  localparam int REF_DIV   = (CLK_HZ >= REF_HZ) ? CLK_HZ / REF_HZ : 1;

  // address_in[9:8] selects the region
  localparam logic [1:0] REG_PORT = 2'h0;
  localparam logic [1:0] REG_CKB  = 2'h1;
  localparam logic [1:0] REG_GLB  = 2'h2;

  // per-port offsets, port k at k*0x20
  localparam logic [4:0] OFF_CTRL  = 5'h00;
  localparam logic [4:0] OFF_DATA  = 5'h04;
  localparam logic [4:0] OFF_COND  = 5'h08;
  localparam logic [4:0] OFF_TIME  = 5'h0c;
  localparam logic [4:0] OFF_COUNT = 5'h10;
  localparam logic [4:0] OFF_STAMP = 5'h14;
  localparam logic [4:0] OFF_STAT  = 5'h18;
  localparam logic [4:0] OFF_LINK  = 5'h00;

  // port control fields
  localparam int CTL_EN    = 0;
  localparam int CTL_OUT   = 1;
  localparam int CTL_OD    = 2;
  localparam int CTL_COND  = 3;
  localparam int CTL_RDY   = 4;
  localparam int CTL_STB   = 5;
  localparam int CTL_TIMED = 6;
  localparam int CTL_CKB   = 8;

  // clock block fields
  localparam int CKB_RUN = 0;
  localparam int CKB_EXT = 1;
  localparam int CKB_DIV = 8;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CKB_RST  = 32'h0000_0000;
  localparam logic        LINK_RST = 1'b0;

  function automatic int port_width(input int k);
    return (k == 0) ? 1 : (2 << k);
  endfunction

  function automatic logic [31:0] port_mask(input int k);
    if (port_width(k) >= 32) begin
      return 32'hffff_ffff;
    end
    return (32'h0000_0001 << port_width(k)) - 32'h0000_0001;
  endfunction
endpackage
`default_nettype wire

// *** hdl/timed_io_port.sv ***
// timed i/o ports with clock blocks behind an avalon-mm slave
//
// Contract
// - ports of 1, 4, 8, 16, 32 bits
// - one direction for all pins of a port
// - drive or sample pins, optional pin condition
// - each access completes in one cycle (here: one wait cycle first, so two)
// - open drain: zero pulls low, one floats
// - shift stage plus transfer register buffer data
// - 16-bit counter schedules each transfer
// - counter readable; transfer deferred to set time
// - counter captured as timestamp on transfer
// - pin events go straight to event outputs
// - enabled link disables ports on its pins
// - narrower port wins shared pins, rest usable
// - port always transfers at full width
// - six clock blocks pace the ports
// - block 0 reference; others programmable
// - clock block may use 1-bit port clock
// - external clock optionally divided
// - ready strobes from outside qualify data
// - output port generates its own strobe
// - after reset ports use clock block 0
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`default_nettype none
module timed_io_port
  import tio_pkg::*;
#(
  parameter int LINK_W = LINK_PINS
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic [9:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  output var  logic [31:0] readdata_out,
  output var  logic        waitrequest_out,
  input  wire logic [31:0] pin_in,
  output var  logic [31:0] pin_out,
  output var  logic [31:0] pin_oe_n_out,
  input  wire logic [4:0]  ready_in,
  output var  logic [4:0]  strobe_out,
  output var  logic [4:0]  event_out
);

  logic [31:0] pin_m_q;
  logic [31:0] pin_s_q;
  logic [4:0]  rdy_m_q;
  logic [4:0]  rdy_s_q;
  logic        pin0_prev_q;

  logic [31:0] ctrl_q  [NPORT];
  logic [31:0] cond_q  [NPORT];
  logic [15:0] time_q  [NPORT];
  logic [31:0] xfer_q  [NPORT];
  logic [31:0] shift_q [NPORT];
  logic [15:0] cnt_q   [NPORT];
  logic [15:0] stamp_q [NPORT];
  logic        full_q  [NPORT];
  logic        stb_q   [NPORT];
  logic        evt_q   [NPORT];
  logic        mv_q    [NPORT];
  logic        arm_q   [NPORT];

  logic [31:0] ckb_q   [NCLK];
  logic [7:0]  div_q   [NCLK];
  logic        tick_q  [NCLK];
  logic        link_en_q;

  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_d;
  logic [31:0] pin_q;
  logic [31:0] oe_n_q;
  logic [31:0] pin_d;
  logic [31:0] oe_n_d;

  logic        wr_go;
  logic        rd_go;
  logic [2:0]  pidx;
  logic [2:0]  cidx;
  logic [4:0]  off;

  // region decodes shared by the read mux and the write enables
  function automatic logic is_port(input logic [9:0] a);
    return a[9:8] == REG_PORT;
  endfunction

  function automatic logic is_ckb(input logic [9:0] a);
    return a[9:8] == REG_CKB && a[1:0] == 2'h0;
  endfunction

  function automatic logic is_link(input logic [9:0] a);
    return a[9:8] == REG_GLB && a[4:0] == OFF_LINK;
  endfunction

  assign wr_go = write_in & ~wait_q;
  assign rd_go = read_in & ~wait_q;
  assign pidx  = address_in[7:5];
  assign cidx  = address_in[4:2];
  assign off   = address_in[4:0];

  assign readdata_out    = rdata_q;
  assign waitrequest_out = wait_q;
  assign pin_out         = pin_q;
  assign pin_oe_n_out    = oe_n_q;

  // pins and strobes come from outside the clock domain
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_m_q     <= 32'h0000_0000;
      pin_s_q     <= 32'h0000_0000;
      rdy_m_q     <= 5'h00;
      rdy_s_q     <= 5'h00;
      pin0_prev_q <= 1'b0;
    end else if (ce_in) begin
      pin_m_q     <= pin_in;
      pin_s_q     <= pin_m_q;
      rdy_m_q     <= ready_in;
      rdy_s_q     <= rdy_m_q;
      pin0_prev_q <= pin_s_q[0];
    end
  end

  // one wait cycle, then the access lands on the low edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_q <= 1'b1;
    end else if (ce_in) begin
      if (wait_q && (read_in || write_in)) begin
        wait_q <= 1'b0;
      end else begin
        wait_q <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    if (is_port(address_in) && pidx < 3'(NPORT)) begin
      case (off)
        OFF_CTRL:  rd_d = ctrl_q[pidx];
        OFF_DATA:  rd_d = xfer_q[pidx];
        OFF_COND:  rd_d = cond_q[pidx];
        OFF_TIME:  rd_d = {16'h0000, time_q[pidx]};
        OFF_COUNT: rd_d = {16'h0000, cnt_q[pidx]};
        OFF_STAMP: rd_d = {16'h0000, stamp_q[pidx]};
        OFF_STAT:  rd_d = {31'h0, full_q[pidx]};
        default:   rd_d = 32'h0000_0000;
      endcase
    end else if (is_ckb(address_in) && cidx < 3'(NCLK)) begin
      rd_d = ckb_q[cidx];
    end else if (is_link(address_in)) begin
      rd_d = {31'h0, link_en_q};
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce_in && wait_q && read_in) begin
      rdata_q <= rd_d;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      link_en_q <= LINK_RST;
    end else if (ce_in && wr_go && is_link(address_in)) begin
      link_en_q <= writedata_in[0];
    end
  end

  // clock blocks: block 0 is the fixed reference tick
  for (genvar j = 0; j < NCLK; j++) begin : g_ckb
    logic       run;
    logic       src_edge;
    logic [7:0] div;
    logic       hit;

    assign hit = wr_go && is_ckb(address_in) && cidx == 3'(j);
    if (j == 0) begin : g_ref
      assign run      = 1'b1;
      assign src_edge = 1'b1;
      assign div      = 8'(REF_DIV - 1);
    end else begin : g_prog
      assign run = ckb_q[j][CKB_RUN];
      // rising edge of the 1-bit port pin when external
      assign src_edge = ckb_q[j][CKB_EXT]
                        ? (pin_s_q[0] & ~pin0_prev_q) : 1'b1;
      assign div = ckb_q[j][CKB_DIV +: 8];
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        ckb_q[j] <= CKB_RST;
      end else if (ce_in && hit && j != 0) begin
        ckb_q[j] <= writedata_in;
      end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        div_q[j]  <= 8'h00;
        tick_q[j] <= 1'b0;
      end else if (ce_in) begin
        tick_q[j] <= 1'b0;
        if (!run) begin
          div_q[j] <= 8'h00;
        end else if (src_edge) begin
          if (div_q[j] >= div) begin
            div_q[j]  <= 8'h00;
            tick_q[j] <= 1'b1;
          end else begin
            div_q[j] <= div_q[j] + 8'h01;
          end
        end
      end
    end
  end

  // ports: width and pin span fixed per index
  for (genvar k = 0; k < NPORT; k++) begin : g_port
    localparam logic [31:0] MASK = port_mask(k);
    logic [2:0]  ckb;
    logic        en;
    logic        dir_out;
    logic        tick;
    logic        time_ok;
    logic        rdy_ok;
    logic        cond_ok;
    logic        out_move;
    logic        in_move;
    logic        hit;
    logic        rd_data;

    assign en      = ctrl_q[k][CTL_EN];
    assign dir_out = ctrl_q[k][CTL_OUT];
    assign ckb     = ctrl_q[k][CTL_CKB +: 3];
    assign tick    = (ckb < 3'(NCLK)) ? tick_q[ckb] : 1'b0;
    assign time_ok = !ctrl_q[k][CTL_TIMED]
                     || cnt_q[k] == time_q[k];
    assign rdy_ok  = !ctrl_q[k][CTL_RDY] || rdy_s_q[k];
    assign cond_ok = !ctrl_q[k][CTL_COND]
                     || shift_q[k] == (cond_q[k] & MASK);
    assign out_move = en && dir_out && tick && full_q[k]
                      && time_ok && rdy_ok;
    assign in_move  = en && !dir_out && tick && time_ok
                      && rdy_ok && cond_ok;
    assign hit     = is_port(address_in) && pidx == 3'(k);
    assign rd_data = rd_go && hit && off == OFF_DATA;

    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        ctrl_q[k] <= CTRL_RST;
        cond_q[k] <= 32'h0000_0000;
        time_q[k] <= 16'h0000;
      end else if (ce_in && wr_go && hit) begin
        if (off == OFF_CTRL) begin
          ctrl_q[k] <= writedata_in;
        end else if (off == OFF_COND) begin
          cond_q[k] <= writedata_in;
        end else if (off == OFF_TIME) begin
          time_q[k] <= writedata_in[15:0];
        end
      end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        cnt_q[k] <= 16'h0000;
      end else if (ce_in && en && tick) begin
        cnt_q[k] <= cnt_q[k] + 16'h0001;
      end
    end

    // transfer register to/from the shift stage
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        xfer_q[k]  <= 32'h0000_0000;
        shift_q[k] <= 32'h0000_0000;
        full_q[k]  <= 1'b0;
        stamp_q[k] <= 16'h0000;
      end else if (ce_in) begin
        if (!dir_out && en && tick) begin
          shift_q[k] <= pin_s_q & MASK;
        end
        if (out_move) begin
          shift_q[k] <= xfer_q[k];
          stamp_q[k] <= cnt_q[k];
        end
        if (in_move) begin
          xfer_q[k]  <= shift_q[k];
          stamp_q[k] <= cnt_q[k];
        end
        // new software data beats the hardware drain
        if (wr_go && hit && off == OFF_DATA && dir_out) begin
          xfer_q[k] <= writedata_in & MASK;
          full_q[k] <= 1'b1;
        end else if (out_move) begin
          full_q[k] <= 1'b0;
        end else if (in_move) begin
          full_q[k] <= 1'b1;
        end else if (rd_data && !dir_out) begin
          full_q[k] <= 1'b0;
        end
      end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        mv_q[k]  <= 1'b0;
        arm_q[k] <= 1'b0;
        stb_q[k] <= 1'b0;
        evt_q[k] <= 1'b0;
      end else if (ce_in) begin
        // pins follow the shift stage a cycle later; pulses wait with them
        mv_q[k]  <= out_move;
        arm_q[k] <= out_move && ctrl_q[k][CTL_STB];
        stb_q[k] <= arm_q[k];
        evt_q[k] <= mv_q[k] || in_move;
      end
    end

    assign strobe_out[k] = stb_q[k];
    assign event_out[k]  = evt_q[k];
  end

  // pin ownership: lowest enabled port covering a pin wins
  always_comb begin
    pin_d  = 32'h0000_0000;
    oe_n_d = 32'hffff_ffff;
    for (int p = 0; p < NPIN; p++) begin
      if (!(link_en_q && p < LINK_W)) begin
        for (int k = NPORT - 1; k >= 0; k--) begin
          if (ctrl_q[k][CTL_EN] && p < port_width(k)) begin
            pin_d[p]  = shift_q[k][p];
            oe_n_d[p] = !ctrl_q[k][CTL_OUT];
            if (ctrl_q[k][CTL_OUT] && ctrl_q[k][CTL_OD]) begin
              pin_d[p]  = 1'b0;
              oe_n_d[p] = shift_q[k][p];
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_q  <= 32'h0000_0000;
      oe_n_q <= 32'hffff_ffff;
    end else if (ce_in) begin
      pin_q  <= pin_d;
      oe_n_q <= oe_n_d;
    end
  end

endmodule // timed_io_port
`default_nettype wire

// *** sim/tio_checker.sv ***
// checker: bus answer, strobe and reset relations at the block's ports
`default_nettype none
module tio_checker (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  input wire logic        read_in,
  input wire logic        write_in,
  input wire logic [31:0] readdata_out,
  input wire logic        waitrequest_out,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe_n_out,
  input wire logic [4:0]  strobe_out,
  input wire logic [4:0]  event_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_req;
    (read_in || write_in) && waitrequest_out && ce_in;
  endsequence
  sequence s_ans;
    !waitrequest_out ##1 waitrequest_out;
  endsequence
  chk_bus_answer: assert property (s_req |=> s_ans)
    else $error("bus request not answered in one cycle");
  chk_wait_cause: assert property (
    $fell(waitrequest_out) |-> $past(read_in || write_in))
    else $error("answer without a request");
  chk_wait_idle: assert property (
    waitrequest_out && !read_in && !write_in |=> waitrequest_out)
    else $error("answer while idle");
  chk_read_hold: assert property (
    $changed(readdata_out) |-> !waitrequest_out && $past(read_in))
    else $error("read data moved outside a read answer");
  chk_strobe_event: assert property (
    |strobe_out |-> (strobe_out & ~event_out) == 5'h0)
    else $error("strobe without transfer");
  chk_strobe_pulse: assert property (
    |strobe_out |=> (strobe_out & $past(strobe_out)) == 5'h0)
    else $error("strobe longer than one cycle");
  chk_reset_release: assert property (
    $fell(rst_in) |-> pin_oe_n_out == 32'hffff_ffff && event_out == 5'h0)
    else $error("pins not released after reset");
  chk_ce_freeze: assert property (
    !ce_in |=> $stable(pin_out) && $stable(pin_oe_n_out))
    else $error("pins moved while frozen");
endmodule // tio_checker
bind timed_io_port tio_checker u_chk (.clk_in, .rst_in, .ce_in, .read_in,
  .write_in, .readdata_out, .waitrequest_out, .pin_out, .pin_oe_n_out,
  .strobe_out, .event_out);
`default_nettype wire

// *** sim/pin_model.sv ***
// partner: pin-side hardware with pull-downs and an external clock
`default_nettype none
module pin_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] pin_drv_in,
  input  wire logic [31:0] pin_oe_n_in,
  input  wire logic [31:0] drive_in,
  input  wire logic        drive_en_in,
  input  wire logic        ckgen_in,
  input  wire logic [4:0]  rdy_in,
  output var  logic [31:0] level_out,
  output var  logic [4:0]  ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        ck_q;
  logic [1:0]  div_q;
  logic [31:0] lvl;
  // clock parks low between bursts so no stray edge reaches a divider
  always_ff @(posedge clk_in) begin
    div_q <= ckgen_in ? div_q + 2'h1 : 2'h0;
    ck_q  <= ckgen_in ? (div_q[0] ? ~ck_q : ck_q) : 1'b0;
  end
  // undriven pins fall to the pull-down level
  assign lvl = (~pin_oe_n_in & pin_drv_in)
             | (pin_oe_n_in & drive_in & {32{drive_en_in}});
  assign level_out = {lvl[31:1], ckgen_in ? ck_q : lvl[0]};
  assign ready_out = rdy_in;
endmodule // pin_model
`default_nettype wire

// *** sim/test_timed_io_port.sv ***
// bench: bus-driven checks of the timed port block against a pin model
`default_nettype none
module test_timed_io_port
  import tio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, ce = 1, rd = 0, wr = 0, ckgen = 0, den = 0;
  logic        wt;
  logic [9:0]  adr = 0;
  logic [31:0] wd = 0, drv = 0, rdat, pin_i, pin_o, oe_n, q, d, m;
  logic [15:0] t;
  logic [4:0]  rdy = 0, rdy_p, stb, ev;
  int          n_fail = 0, n_tests = 0, k, c;
  always #12.5 clk = ~clk;
  timed_io_port DUT (.clk_in(clk), .rst_in(rst), .ce_in(ce),
    .address_in(adr), .read_in(rd), .write_in(wr), .writedata_in(wd),
    .readdata_out(rdat), .waitrequest_out(wt), .pin_in(pin_i),
    .pin_out(pin_o), .pin_oe_n_out(oe_n), .ready_in(rdy_p),
    .strobe_out(stb), .event_out(ev));
  pin_model u_pins (.clk_in(clk), .pin_drv_in(pin_o), .pin_oe_n_in(oe_n),
    .drive_in(drv), .drive_en_in(den), .ckgen_in(ckgen), .rdy_in(rdy),
    .level_out(pin_i), .ready_out(rdy_p));
  task automatic conclude();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    conclude();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input int a, input logic [31:0] v);
    int i;
    adr <= 10'(a);
    wd <= v;
    rd <= !w;
    wr <= w;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wt !== 1'b0 && i < 20);
    if (i >= 20) hang();
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input int a, input logic [31:0] e);
    bus(0, a, 0);
    chk(q, e);
  endtask
  task automatic wev(input int p);
    c = 0;
    while (ev[p] !== 1'b1) begin
      @(posedge clk);
      c++;
      if (c > 99) hang();
    end
  endtask
  function automatic int pa(input int p, input logic [4:0] o);
    return p * 32 + int'(o);
  endfunction
  function automatic logic [31:0] msk(input int p);
    if (p == 4) return 32'hffff_ffff;
    return (32'h1 << (p == 0 ? 1 : 2 << p)) - 32'h1;
  endfunction
  initial begin
    q = $urandom(32'h1e39);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 5; k++) rdc(pa(k, OFF_CTRL), CTRL_RST);
    rdc(32'h104, CKB_RST);
    rdc(32'h3fc, 0);
    $display("done reset values");
    for (k = 0; k < 5; k++) begin
      d = $urandom;
      m = msk(k);
      bus(1, pa(k, OFF_CTRL), 32'h63);
      bus(0, pa(k, OFF_COUNT), 0);
      t = q[15:0] + 16'd40;
      bus(1, pa(k, OFF_TIME), {16'h0, t});
      bus(1, pa(k, OFF_DATA), d);
      wev(k);
      chk(pin_o & m, d & m);
      chk(oe_n, ~m);
      chk(stb[k], 1);
      chk(c > 20, 1);
      rdc(pa(k, OFF_STAMP), {16'h0, t});
      bus(1, pa(k, OFF_CTRL), 0);
      @(posedge clk);
      chk(oe_n, 32'hffff_ffff);
    end
    $display("done timed output");
    bus(1, pa(1, OFF_CTRL), 32'h7);
    bus(1, pa(1, OFF_DATA), 32'ha);
    wev(1);
    chk(oe_n[3:0], 4'ha);
    chk(pin_o[3:0], 4'h0);
    chk(stb[1], 0);
    bus(1, pa(1, OFF_CTRL), 32'h13);
    d = $urandom;
    bus(1, pa(1, OFF_DATA), d);
    repeat (10) @(posedge clk);
    rdc(pa(1, OFF_STAT), 1);
    rdy <= 5'h2;
    wev(1);
    chk(pin_o[3:0], d[3:0]);
    rdy <= 5'h0;
    bus(1, pa(1, OFF_CTRL), 0);
    $display("done drain and ready");
    den <= 1'b1;
    drv <= {d[31:8], 8'h33};
    bus(1, pa(2, OFF_COND), 32'h5a);
    bus(1, pa(2, OFF_CTRL), 32'h9);
    repeat (10) @(posedge clk);
    rdc(pa(2, OFF_STAT), 0);
    drv <= {d[31:8], 8'h5a};
    repeat (10) @(posedge clk);
    rdc(pa(2, OFF_STAT), 1);
    rdc(pa(2, OFF_DATA), 32'h5a);
    bus(1, pa(2, OFF_CTRL), 0);
    den <= 1'b0;
    $display("done conditional input");
    for (k = 0; k < 2; k++) begin
      bus(1, 32'h104, {16'h0, 8'(k), 8'h3});
      bus(1, pa(2, OFF_CTRL), 32'h101);
      bus(0, pa(2, OFF_COUNT), 0);
      t = q[15:0] + 16'(8 / (k + 1));
      ckgen <= 1'b1;
      repeat (32) @(posedge clk);
      ckgen <= 1'b0;
      repeat (8) @(posedge clk);
      rdc(pa(2, OFF_COUNT), {16'h0, t});
      bus(1, pa(2, OFF_CTRL), 0);
    end
    $display("done external clock");
    d = $urandom;
    bus(1, pa(4, OFF_CTRL), 32'h3);
    bus(1, pa(4, OFF_DATA), d);
    wev(4);
    bus(1, pa(1, OFF_CTRL), 32'h1);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    chk(oe_n, 32'hf);
    chk(pin_o[31:4], d[31:4]);
    bus(1, pa(1, OFF_CTRL), 0);
    @(posedge clk);
    chk(oe_n, 0);
    bus(1, 32'h200, 1);
    @(posedge clk);
    chk(oe_n, 32'hf);
    bus(1, 32'h200, 0);
    @(posedge clk);
    chk(oe_n, 0);
    $display("done sharing");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(oe_n, 32'hffff_ffff);
    rdc(pa(4, OFF_CTRL), 0);
    $display("done second reset");
    conclude();
  end
endmodule // test_timed_io_port
`default_nettype wire
